// ==== rtl/abu_regs.svh ====
`ifndef ABU_REGS_SVH
`define ABU_REGS_SVH
// register word offsets (one 32-bit word each)
`define ABU_OFS_STATUS_CONTROL 4'h0
`define ABU_OFS_ADDR_HIGH 4'h1
`define ABU_OFS_ADDR_LOW 4'h2
`define ABU_OFS_AUXILIARY 4'h3
`define ABU_OFS_WAIT_EXIT 4'h4
`define ABU_OFS_FLAG_CLEAR 4'h5
`define ABU_OFS_IRQ_STATUS 4'h6
`define ABU_OFS_IRQ_MASK 4'h7
// field positions
`define ABU_BIT_ENABLE 7
`define ABU_BIT_ACTIVE 6
`define ABU_BIT_WDOG_OFF 0
`define ABU_BIT_WAIT_EXIT 1
`define ABU_BIT_FLAG_CLEAR 7
`define ABU_IRQ_BIT_MATCH 0
`define ABU_IRQ_BIT_SOFT 1
// vectors
`define ABU_VECTOR_NORMAL 16'hfffc
`define ABU_VECTOR_MONITOR 16'hfefc
// reset values
`define ABU_RST_BYTE 8'h00
`endif

// ==== rtl/abu_pkg.sv ====
package abu_pkg;
  // break sequencing states
  typedef enum logic [1:0] {
    ABU_IDLE = 2'b00,
    ABU_REQ = 2'b01,
    ABU_IN_BREAK = 2'b10
  } abu_state_t;
  // cpu bus view
  typedef struct packed {
    logic [15:0] addr;
    logic fetch;
    logic opcode;
    logic instr_start;
    logic rti_done;
    logic wait_mode;
    logic stop_mode;
    logic monitor;
  } abu_cpu_t;
  // all module state
  typedef struct packed {
    abu_state_t state;
    logic enable;
    logic active;
    logic [15:0] brk_addr;
    logic wdog_off;
    logic wait_exit;
    logic flag_clear;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic pend_operand;
    logic armed;
    logic [15:0] last_addr;
    logic breakpoint_request;
    logic [15:0] vector;
    logic timer_stop;
    logic wdog_hold;
    logic clear_allow;
    logic irq;
    logic waitreq;
    logic [31:0] rdata;
  } abu_state_reg_t;
endpackage : abu_pkg

// ==== rtl/abu_address_breakpoint_unit.sv ====
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "abu_regs.svh"
module abu_address_breakpoint_unit (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // avalon-mm slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // cpu and system integration unit
  input wire abu_pkg::abu_cpu_t cpu_in,
  output logic breakpoint_request_out,
  output logic [15:0] break_vector_out,
  output logic timer_stop_out,
  output logic watchdog_hold_out,
  output logic status_clear_allow_out,
  // interrupt
  output logic irq_out
);

  abu_pkg::abu_state_reg_t st_r;
  abu_pkg::abu_state_reg_t st_nxt;
  logic access;
  logic wr;
  logic hit;
  logic [31:0] rd;
  logic [1:0] ev;

  // ****************************************
  // register access and break sequencing
  // ****************************************

  // one wait state; a write lands at the edge that sees waitrequest low
  assign access = (avs_read_in | avs_write_in) & st_r.waitreq;
  assign wr = avs_write_in & ~st_r.waitreq & avs_byteenable_in[0];

  // address compare, fetch qualified, not in low power
  assign hit = st_r.enable & cpu_in.fetch & ~cpu_in.wait_mode
    & ~cpu_in.stop_mode & (cpu_in.addr == st_r.brk_addr)
    & ~(st_r.armed == 1'b0 && cpu_in.addr == st_r.last_addr);

  // read mux
  always_comb begin
    rd = 32'h0000_0000;
    case (avs_address_in)
      `ABU_OFS_STATUS_CONTROL: rd[7:0] = {st_r.enable, st_r.active, 6'h00};
      `ABU_OFS_ADDR_HIGH: rd[7:0] = st_r.brk_addr[15:8];
      `ABU_OFS_ADDR_LOW: rd[7:0] = st_r.brk_addr[7:0];
      `ABU_OFS_AUXILIARY: rd[`ABU_BIT_WDOG_OFF] = st_r.wdog_off;
      `ABU_OFS_WAIT_EXIT: rd[`ABU_BIT_WAIT_EXIT] = st_r.wait_exit;
      `ABU_OFS_FLAG_CLEAR: rd[`ABU_BIT_FLAG_CLEAR] = st_r.flag_clear;
      `ABU_OFS_IRQ_STATUS: rd[1:0] = st_r.irq_status;
      `ABU_OFS_IRQ_MASK: rd[1:0] = st_r.irq_mask;
      default: rd = 32'h0000_0000;
    endcase
  end

  // next state
  always_comb begin
    st_nxt = st_r;
    ev = 2'b00;
    st_nxt.waitreq = ~access;
    st_nxt.rdata = access ? rd : st_r.rdata;
    if (wr) begin
      case (avs_address_in)
        `ABU_OFS_STATUS_CONTROL: begin
          st_nxt.enable = avs_writedata_in[`ABU_BIT_ENABLE];
          if (avs_writedata_in[`ABU_BIT_ACTIVE]) begin
            st_nxt.active = 1'b1;
            ev[`ABU_IRQ_BIT_SOFT] = 1'b1;
            if (st_r.state == abu_pkg::ABU_IDLE)
              st_nxt.state = abu_pkg::ABU_REQ;
          end else begin
            st_nxt.active = 1'b0;
            st_nxt.armed = 1'b0;
          end
        end
        `ABU_OFS_ADDR_HIGH: begin
          st_nxt.brk_addr[15:8] = avs_writedata_in[7:0];
          st_nxt.armed = 1'b1;
        end
        `ABU_OFS_ADDR_LOW: begin
          st_nxt.brk_addr[7:0] = avs_writedata_in[7:0];
          st_nxt.armed = 1'b1;
        end
        `ABU_OFS_AUXILIARY:
          st_nxt.wdog_off = avs_writedata_in[`ABU_BIT_WDOG_OFF];
        `ABU_OFS_WAIT_EXIT:
          st_nxt.wait_exit = st_r.wait_exit & avs_writedata_in[1];
        `ABU_OFS_FLAG_CLEAR:
          st_nxt.flag_clear = avs_writedata_in[`ABU_BIT_FLAG_CLEAR];
        `ABU_OFS_IRQ_STATUS:
          st_nxt.irq_status = st_r.irq_status & ~avs_writedata_in[1:0];
        `ABU_OFS_IRQ_MASK: st_nxt.irq_mask = avs_writedata_in[1:0];
        default: ;
      endcase
    end
    case (st_r.state)
      abu_pkg::ABU_IDLE: begin
        if (hit) begin
          st_nxt.active = 1'b1;
          st_nxt.last_addr = cpu_in.addr;
          ev[`ABU_IRQ_BIT_MATCH] = 1'b1;
          if (cpu_in.opcode) st_nxt.state = abu_pkg::ABU_REQ;
          else st_nxt.pend_operand = 1'b1;
        end
        if (st_r.pend_operand && cpu_in.instr_start) begin
          st_nxt.pend_operand = 1'b0;
          st_nxt.state = abu_pkg::ABU_REQ;
        end
      end
      abu_pkg::ABU_REQ: begin
        // request stands until next instruction start or entry to wait mode
        if (cpu_in.instr_start || cpu_in.wait_mode) begin
          st_nxt.state = abu_pkg::ABU_IN_BREAK;
          st_nxt.wait_exit = cpu_in.wait_mode;
        end
      end
      abu_pkg::ABU_IN_BREAK: begin
        if (cpu_in.rti_done) st_nxt.state = abu_pkg::ABU_IDLE;
      end
      default: st_nxt.state = abu_pkg::ABU_IDLE;
    endcase
    if (hit) st_nxt.armed = 1'b1;
    // sticky events: set beats clear
    st_nxt.irq_status = st_nxt.irq_status | ev;
    st_nxt.breakpoint_request = (st_nxt.state == abu_pkg::ABU_REQ);
    st_nxt.vector = cpu_in.monitor ? `ABU_VECTOR_MONITOR
      : `ABU_VECTOR_NORMAL;
    st_nxt.timer_stop = (st_nxt.state == abu_pkg::ABU_IN_BREAK);
    st_nxt.wdog_hold = st_nxt.timer_stop & cpu_in.monitor
      & st_nxt.wdog_off;
    st_nxt.clear_allow = ~st_nxt.timer_stop | st_nxt.flag_clear;
    st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_mask);
  end

  // state register
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
      st_r.state <= abu_pkg::ABU_IDLE;
      st_r.waitreq <= 1'b1;
      st_r.clear_allow <= 1'b1;
      st_r.vector <= `ABU_VECTOR_NORMAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops
  assign avs_readdata_out = st_r.rdata;
  assign avs_waitrequest_out = st_r.waitreq;
  assign breakpoint_request_out = st_r.breakpoint_request;
  assign break_vector_out = st_r.vector;
  assign timer_stop_out = st_r.timer_stop;
  assign watchdog_hold_out = st_r.wdog_hold;
  assign status_clear_allow_out = st_r.clear_allow;
  assign irq_out = st_r.irq;

endmodule : abu_address_breakpoint_unit
`default_nettype wire

// ==== tb/abu_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// cpu side: fetches, instruction starts, returns, modes
module abu_cpu_model (
  // clock and cpu bus view
  input wire logic core_clk_in,
  output var abu_pkg::abu_cpu_t cpu_out
);
  initial cpu_out = '0;
  // one fetch cycle, address scrambled once released
  task automatic fetch(input logic [15:0] a, input logic op);
    cpu_out <= {a, 1'b1, op, op, 1'b0, cpu_out[2:0]};
    @(posedge core_clk_in);
    cpu_out <= {~a, 4'h0, cpu_out[2:0]};
  endtask : fetch
  // one cycle of instruction start or return
  task automatic pulse(input logic [1:0] sr);
    cpu_out[4:3] <= sr;
    @(posedge core_clk_in);
    cpu_out[4:3] <= 2'b00;
  endtask : pulse
  // wait, stop, monitor levels; no fetches while waiting
  task automatic mode(input logic [2:0] m);
    cpu_out[2:0] <= m;
  endtask : mode
endmodule : abu_cpu_model
`default_nettype wire

// ==== tb/abu_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "abu_regs.svh"
// break sequencing checks at the cpu side
module abu_monitor (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire abu_pkg::abu_cpu_t cpu_in,
  input wire logic breakpoint_request_out,
  input wire logic [15:0] break_vector_out,
  input wire logic timer_stop_out,
  input wire logic watchdog_hold_out,
  input wire logic status_clear_allow_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  req_hold_a: assert property (
    breakpoint_request_out && !cpu_in.instr_start && !cpu_in.wait_mode
    |=> breakpoint_request_out) else $error("request dropped");
  mon_vector_a: assert property (
    cpu_in.monitor ##1 cpu_in.monitor
    |-> break_vector_out == `ABU_VECTOR_MONITOR) else $error("bad vector");
  brk_enter_a: assert property (
    breakpoint_request_out && cpu_in.instr_start
    |=> timer_stop_out && !breakpoint_request_out) else $error("no entry");
  brk_exit_a: assert property (
    timer_stop_out && cpu_in.rti_done |=> !timer_stop_out)
    else $error("break not left");
  timer_hold_a: assert property (
    timer_stop_out && !cpu_in.rti_done |=> timer_stop_out)
    else $error("timer released");
  wdog_hold_a: assert property (
    watchdog_hold_out |-> timer_stop_out) else $error("stray hold");
  clear_open_a: assert property (
    !timer_stop_out |-> status_clear_allow_out) else $error("clear shut");
  stop_quiet_a: assert property (
    cpu_in.stop_mode && !breakpoint_request_out
    |=> !breakpoint_request_out) else $error("break in stop");
endmodule : abu_monitor
bind abu_address_breakpoint_unit abu_monitor i_mon (.core_clk_in,
  .rst_n_in, .cpu_in, .breakpoint_request_out, .break_vector_out,
  .timer_stop_out, .watchdog_hold_out, .status_clear_allow_out);
`default_nettype wire

// ==== tb/test_abu_address_breakpoint_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "abu_regs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
  miscompares++; $display("Error %0t got %h exp %h", $time, g, e); end end
module test_abu_address_breakpoint_unit;
  logic core_clk_in = 0;
  logic rst_n_in = 0;
  logic rd = 0;
  logic wr = 0;
  logic [3:0] adr = 0;
  logic [3:0] be = 4'hf;
  logic [31:0] wd = 0;
  logic [31:0] rdat;
  logic [15:0] a;
  int miscompares = 0;
  int n_compared = 0;
  int seed = 32'hc2943e92;
  wire logic [31:0] rdo;
  wire logic wq, breakpoint_request, tstop, whold, clr, irq;
  wire logic [15:0] vec;
  wire abu_pkg::abu_cpu_t cpu;
  // 20 MHz clock
  always #25 core_clk_in = ~core_clk_in;
  abu_cpu_model i_cpu (.core_clk_in, .cpu_out(cpu));
  abu_address_breakpoint_unit i_dut (.core_clk_in, .rst_n_in,
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(be),
    .avs_readdata_out(rdo), .avs_waitrequest_out(wq), .cpu_in(cpu),
    .breakpoint_request_out(breakpoint_request), .break_vector_out(vec),
    .timer_stop_out(tstop), .watchdog_hold_out(whold),
    .status_clear_allow_out(clr), .irq_out(irq));
  function automatic logic [15:0] exp_vec(input logic m);
    return m ? `ABU_VECTOR_MONITOR : `ABU_VECTOR_NORMAL;
  endfunction : exp_vec
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] ad, input logic [7:0] d);
    rd <= ~w;
    wr <= w;
    adr <= ad;
    wd <= {24'h0, d};
    do @(posedge core_clk_in); while (wq !== 1'b0);
    rdat = rdo;
    rd <= 1'b0;
    wr <= 1'b0;
    repeat (2) @(posedge core_clk_in);
  endtask : bus
  task automatic arm(input logic [15:0] ba, input logic [7:0] ctl);
    bus(1, `ABU_OFS_ADDR_HIGH, ba[15:8]);
    bus(1, `ABU_OFS_ADDR_LOW, ba[7:0]);
    bus(1, `ABU_OFS_STATUS_CONTROL, ctl);
  endtask : arm
  // enter break, clear active, return
  task automatic leave;
    i_cpu.pulse(2'b10);
    bus(1, `ABU_OFS_STATUS_CONTROL, 8'h80);
    i_cpu.pulse(2'b01);
    @(posedge core_clk_in);
    `CHK(tstop, 1'b0)
  endtask : leave
  task automatic results;
    if (miscompares == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // watchdog
  initial begin
    repeat (3000) @(posedge core_clk_in);
    miscompares++;
    results();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(posedge core_clk_in);
    bus(1, 4'hf, 8'hff);
    // write with byte lane 0 off must be ignored
    be <= 4'he;
    bus(1, `ABU_OFS_ADDR_HIGH, 8'hff);
    be <= 4'hf;
    for (int i = 0; i < 6; i++) begin
      bus(0, 4'(i), 0);
      `CHK(rdat, 32'h0)
    end
    bus(0, 4'hf, 0);
    `CHK(rdat, 32'h0)
    a = 16'($random(seed));
    i_cpu.mode(3'b001);
    bus(1, `ABU_OFS_AUXILIARY, 8'h01);
    bus(1, `ABU_OFS_IRQ_MASK, 8'h01);
    arm(a, 8'h80);
    i_cpu.fetch(a, 1);
    @(posedge core_clk_in);
    `CHK(breakpoint_request, 1'b1)
    `CHK(vec, exp_vec(1))
    bus(0, `ABU_OFS_STATUS_CONTROL, 0);
    `CHK({rdat[7:0], irq}, 9'h181)
    i_cpu.pulse(2'b10);
    @(posedge core_clk_in);
    `CHK({tstop, whold, clr}, 3'b110)
    bus(1, `ABU_OFS_FLAG_CLEAR, 8'h80);
    `CHK(clr, 1'b1)
    bus(1, `ABU_OFS_IRQ_STATUS, 8'h03);
    `CHK(irq, 1'b0)
    leave();
    i_cpu.fetch(a, 1);
    repeat (3) @(posedge core_clk_in);
    `CHK(breakpoint_request, 1'b0)
    a = ~a;
    i_cpu.mode(3'b000);
    arm(a, 8'h80);
    i_cpu.fetch(a, 0);
    @(posedge core_clk_in);
    `CHK(breakpoint_request, 1'b0)
    i_cpu.pulse(2'b10);
    @(posedge core_clk_in);
    `CHK({breakpoint_request, vec}, {1'b1, exp_vec(0)})
    leave();
    bus(1, `ABU_OFS_STATUS_CONTROL, 8'hc0);
    `CHK(breakpoint_request, 1'b1)
    leave();
    i_cpu.mode(3'b100);
    bus(1, `ABU_OFS_STATUS_CONTROL, 8'hc0);
    bus(0, `ABU_OFS_WAIT_EXIT, 0);
    `CHK(rdat[7:0], 8'h02)
    i_cpu.mode(3'b010);
    leave();
    i_cpu.mode(3'b000);
    a = 16'($random(seed));
    arm(a, 8'h00);
    i_cpu.fetch(a, 1);
    repeat (3) @(posedge core_clk_in);
    `CHK(breakpoint_request, 1'b0)
    results();
  end
endmodule : test_abu_address_breakpoint_unit
`default_nettype wire
